// ===== rtl/buck_ctrl_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef BUCK_CTRL_MAP_SVH
`define BUCK_CTRL_MAP_SVH
`define OFS_MODE_CONTROL 8'h03
`define OFS_DISCHARGE_CONTROL 8'h04
`define OFS_LOW_TARGET 8'h05
`define OFS_HIGH_TARGET 8'h06
`define OFS_SLEW_RATE 8'h07
`define BIT_BUCK1_FORCED_PWM 1
`define BIT_BUCK2_FORCED_PWM 0
`define BIT_IN_PROGRESS 7
`define RST_MODE_CONTROL 8'h01
`define RST_DISCHARGE 6'h0F
`define RST_LOW_TARGET 6'h10
`define RST_HIGH_TARGET 6'h08
`define RST_SLEW_RATE 3'h6
`define SLEW_IMMEDIATE 3'h7
// Step time at the slowest rate code, in ns; each higher code up to 6 halves it
`define STEP_SLOWEST_NS 227272
`define CLK_PERIOD_NS 5
`define STEP_SLOWEST_CYCLES (`STEP_SLOWEST_NS / `CLK_PERIOD_NS)
`endif

// ===== rtl/buck_ctrl_pkg.sv
// Types shared by the converter control registers
`default_nettype none
package buck_ctrl_pkg;
  typedef logic [5:0] vcode_t;
  typedef logic [2:0] slew_t;
  typedef enum logic {SLEW_IDLE, SLEW_MOVING} slew_state_t;
endpackage
`default_nettype wire

// ===== rtl/buck_voltage_mode_control_regs.sv
// Converter mode, discharge and dynamic voltage control registers
// What this block does
// - Mode bit 1 high forces converter one into fixed-frequency PWM.
// - Mode bit 0 high forces converter two into fixed-frequency PWM.
// - Discharge register bit 7 reads 1 while a converter two transition runs.
// - Code steps toward the selected target at the slew-rate setting pace.
// - Busy flag is internal only; serial writes to bit 7 cannot change it.
// - Transition ends when stepped code equals target, not on regulation.
// - Select pin level change starts a slewed transition and raises busy.
// - Discharge bits 5..0 enable active discharge of disabled rails.
// - Bit 5 converter one, 4 converter two, 3..0 regulators; resets 0,0,1111.
// - Target is low register when select low, high register when high.
// - Codes 0..31 map from 0.800 V in 25 mV steps.
// - Low target resets to 10h, high target to 08h, code in bits 5..0.
// - Slew register holds 3-bit rate, reset 06h; code 111 is immediate.
`include "buck_ctrl_map.svh"
`default_nettype none
module buck_voltage_mode_control_regs #(
  parameter int STEP_SLOWEST_CYCLES = `STEP_SLOWEST_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Register access
  input wire logic wr_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // Pins
  input wire logic voltage_select_pin_i,
  input wire logic [5:0] rail_enabled_i,
  // Converter control
  output logic buck1_forced_pwm_o,
  output logic buck2_forced_pwm_o,
  output logic [5:0] discharge_active_o,
  output logic [5:0] buck2_voltage_code_o,
  output logic [15:0] buck2_output_mv_o,
  output logic transition_busy_o
);

  // ----------------------------------------
  // Select pin synchroniser
  // ----------------------------------------
  logic sel_meta_q, sel_sync_q, sel_prev_q;
  logic sel_meta_d, sel_sync_d, sel_prev_d;

  // Third flop keeps the previous synced level for edge detection
  always_comb
  begin
    sel_meta_d = voltage_select_pin_i;
    sel_sync_d = sel_meta_q;
    sel_prev_d = sel_sync_q;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      sel_meta_q <= 1'b0;
      sel_sync_q <= 1'b0;
      sel_prev_q <= 1'b0;
    end
    else
    begin
      sel_meta_q <= sel_meta_d;
      sel_sync_q <= sel_sync_d;
      sel_prev_q <= sel_prev_d;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] mode_q, mode_d;
  logic [5:0] dis_q, dis_d;
  buck_ctrl_pkg::vcode_t low_q, low_d, high_q, high_d;
  buck_ctrl_pkg::slew_t slew_q, slew_d;
  logic tgt_write;

  // Reserved bits dropped on write, so they read zero; mode bits 3..2 are kept and read back
  always_comb
  begin
    mode_d = mode_q;
    dis_d = dis_q;
    low_d = low_q;
    high_d = high_q;
    slew_d = slew_q;
    tgt_write = 1'b0;
    // Writes land on the edge where the enable is sampled high
    if (wr_en_i)
    begin
      case (addr_i)
        `OFS_MODE_CONTROL: mode_d = {4'h0, wdata_i[3:0]};
        `OFS_DISCHARGE_CONTROL: dis_d = wdata_i[5:0];
        `OFS_LOW_TARGET:
        begin
          low_d = wdata_i[5:0];
          tgt_write = 1'b1;
        end
        `OFS_HIGH_TARGET:
        begin
          high_d = wdata_i[5:0];
          tgt_write = 1'b1;
        end
        `OFS_SLEW_RATE: slew_d = wdata_i[2:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      mode_q <= `RST_MODE_CONTROL;
      dis_q <= `RST_DISCHARGE;
      low_q <= `RST_LOW_TARGET;
      high_q <= `RST_HIGH_TARGET;
      slew_q <= `RST_SLEW_RATE;
    end
    else
    begin
      mode_q <= mode_d;
      dis_q <= dis_d;
      low_q <= low_d;
      high_q <= high_d;
      slew_q <= slew_d;
    end
  end

  // ----------------------------------------
  // Voltage stepping
  // ----------------------------------------
  buck_ctrl_pkg::slew_state_t st_q, st_d;
  buck_ctrl_pkg::vcode_t code_q, code_d, target;
  logic [31:0] tick_q, tick_d, step_len;
  logic start;

  assign target = sel_sync_q ? high_q : low_q;
  // Any target write starts a transition from idle, even one to the unselected register; while moving, start is ignored
  assign start = tgt_write || (sel_sync_q != sel_prev_q);
  // Zero step length gives one step per clock
  assign step_len = 32'(STEP_SLOWEST_CYCLES) >> slew_q;

  always_comb
  begin
    st_d = st_q;
    code_d = code_q;
    tick_d = tick_q;
    case (st_q)
      buck_ctrl_pkg::SLEW_IDLE:
      begin
        tick_d = 32'h0;
        // Also leaves idle when code differs from target; reset loads code equal to the low target
        if (start || code_q != target)
          st_d = buck_ctrl_pkg::SLEW_MOVING;
      end
      buck_ctrl_pkg::SLEW_MOVING:
      begin
        if (code_q == target)
        begin
          st_d = buck_ctrl_pkg::SLEW_IDLE;
        end
        else if (slew_q == `SLEW_IMMEDIATE)
        begin
          code_d = target;
        end
        else if (tick_q + 32'h1 >= step_len)
        begin
          tick_d = 32'h0;
          code_d = (code_q < target) ? code_q + 6'h01 : code_q - 6'h01;
        end
        else
        begin
          tick_d = tick_q + 32'h1;
        end
      end
      default: st_d = buck_ctrl_pkg::SLEW_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      st_q <= buck_ctrl_pkg::SLEW_IDLE;
      code_q <= `RST_LOW_TARGET;
      tick_q <= 32'h0;
    end
    else
    begin
      st_q <= st_d;
      code_q <= code_d;
      tick_q <= tick_d;
    end
  end

  // ----------------------------------------
  // Outputs and read-back
  // ----------------------------------------
  // Busy is sequencer state only; the host cannot write it
  logic busy;
  assign busy = (st_q == buck_ctrl_pkg::SLEW_MOVING);

  always_comb
  begin
    case (addr_i)
      `OFS_MODE_CONTROL: rdata_o = mode_q;
      `OFS_DISCHARGE_CONTROL: rdata_o = {busy, 1'b0, dis_q};
      `OFS_LOW_TARGET: rdata_o = {2'b00, low_q};
      `OFS_HIGH_TARGET: rdata_o = {2'b00, high_q};
      `OFS_SLEW_RATE: rdata_o = {5'h00, slew_q};
      default: rdata_o = 8'h00;
    endcase
  end

  assign buck1_forced_pwm_o = mode_q[`BIT_BUCK1_FORCED_PWM];
  assign buck2_forced_pwm_o = mode_q[`BIT_BUCK2_FORCED_PWM];
  assign discharge_active_o = dis_q & ~rail_enabled_i;
  assign buck2_voltage_code_o = code_q;
  // Only the lower half of the code table is modelled
  assign buck2_output_mv_o = 16'h0320 + 16'(code_q[4:0]) * 16'h0019;
  assign transition_busy_o = busy;

endmodule
`default_nettype wire

// ===== tb/buck_ctrl_properties.sv
// Checker of the converter control register ports
`default_nettype none
module buck_ctrl_properties (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Register read
  input wire logic [7:0] addr_i,
  input wire logic [7:0] rdata_o,
  // Pins and outputs
  input wire logic [5:0] rail_enabled_i,
  input wire logic voltage_select_pin_i,
  input wire logic buck1_forced_pwm_o,
  input wire logic buck2_forced_pwm_o,
  input wire logic [5:0] discharge_active_o,
  input wire logic [5:0] buck2_voltage_code_o,
  input wire logic [15:0] buck2_output_mv_o,
  input wire logic transition_busy_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_move; $changed(buck2_voltage_code_o); endsequence
  property p_pwm1; addr_i == 8'h03 |-> rdata_o[1] == buck1_forced_pwm_o; endproperty
  property p_pwm2; addr_i == 8'h03 |-> rdata_o[0] == buck2_forced_pwm_o; endproperty
  property p_busy; addr_i == 8'h04 |-> rdata_o[7] == transition_busy_o; endproperty
  property p_step; s_move |-> $past(transition_busy_o); endproperty
  property p_dis; addr_i == 8'h04 |-> discharge_active_o == (rdata_o[5:0] & ~rail_enabled_i);
  endproperty
  property p_mv; buck2_output_mv_o == 16'h0320 + 16'h0019 * buck2_voltage_code_o[4:0]; endproperty
  property p_tgt; addr_i inside {8'h05, 8'h06} |-> rdata_o[7:6] == 2'h0; endproperty
  property p_rsv; addr_i == 8'h04 |-> !rdata_o[6]; endproperty
  sequence s_pin_edge; $changed(voltage_select_pin_i); endsequence
  property p_pin; s_pin_edge |-> ##[1:4] transition_busy_o; endproperty
  property p_rst; $rose(resetn_i) |-> buck2_voltage_code_o == 6'h10 && !transition_busy_o;
  endproperty
  property p_fall; $fell(transition_busy_o) |-> $stable(buck2_voltage_code_o); endproperty
  property p_slew; addr_i == 8'h07 |-> rdata_o[7:3] == 5'h00; endproperty
  a_pwm1: assert property (p_pwm1) else $error("mode bit 1 differs");
  a_pwm2: assert property (p_pwm2) else $error("mode bit 0 differs");
  a_busy: assert property (p_busy) else $error("busy bit differs");
  a_step: assert property (p_step) else $error("code moved while idle");
  a_dis: assert property (p_dis) else $error("discharge wrong");
  a_mv: assert property (p_mv) else $error("millivolts wrong");
  a_tgt: assert property (p_tgt) else $error("target top bits set");
  a_rsv: assert property (p_rsv) else $error("bit 6 set");
  a_pin: assert property (p_pin) else $error("pin change without busy");
  a_rst: assert property (p_rst) else $error("code or busy wrong after reset");
  a_fall: assert property (p_fall) else $error("busy ended while code moved");
  a_slew: assert property (p_slew) else $error("slew top bits set");
endmodule
bind buck_voltage_mode_control_regs buck_ctrl_properties u_chk (.mclk_i, .resetn_i, .addr_i,
  .rdata_o, .rail_enabled_i, .voltage_select_pin_i, .buck1_forced_pwm_o, .buck2_forced_pwm_o,
  .discharge_active_o,
  .buck2_voltage_code_o, .buck2_output_mv_o, .transition_busy_o);
`default_nettype wire

// ===== tb/host_model.sv
// Host model that drives register writes and reads
`default_nettype none
module host_model (
  // Clock
  input wire logic mclk_i,
  // Register access
  output logic wr_en_o = 1'b0,
  output logic rd_v_o = 1'b0,
  output logic [7:0] addr_o = 8'h00,
  output logic [7:0] wdata_o = 8'h00
);
  timeunit 1ns;
  timeprecision 100ps;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_en_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge mclk_i);
    wr_en_o <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    addr_o <= a;
    rd_v_o <= 1'b1;
    @(posedge mclk_i);
    rd_v_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== tb/buck_voltage_mode_control_regs_tb_top.sv
// Testbench of the converter control registers
`default_nettype none
module buck_voltage_mode_control_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic pin = 1'b0;
  logic [5:0] rails = 6'h00;
  logic wr_en, rd_v;
  logic [7:0] addr, wdata, rdata, dis;
  logic [5:0] code;
  logic [31:0] rng = 32'h14;
  logic [15:0] rst_t [5] = '{16'h0301, 16'h040F, 16'h0510, 16'h0608, 16'h0706};
  logic [7:0] exp_q [$];
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #2.5 mclk_i = ~mclk_i;
  host_model host (.mclk_i, .wr_en_o(wr_en), .rd_v_o(rd_v), .addr_o(addr), .wdata_o(wdata));
  buck_voltage_mode_control_regs #(.STEP_SLOWEST_CYCLES(8)) DUT (.mclk_i, .resetn_i,
    .wr_en_i(wr_en), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
    .voltage_select_pin_i(pin), .rail_enabled_i(rails), .buck1_forced_pwm_o(),
    .buck2_forced_pwm_o(), .discharge_active_o(), .buck2_voltage_code_o(code),
    .buck2_output_mv_o(), .transition_busy_o());
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask
  always @(negedge mclk_i)
    if (rd_v === 1'b1)
      cmp8(rdata, exp_q.pop_front());
  always @(posedge mclk_i)
  begin
    rng <= xs(rng);
    rails <= rng[5:0];
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      err_count++;
      finish_test();
    end
  end
  initial
  begin
    repeat (8) @(posedge mclk_i);
    resetn_i <= 1'b1;
    foreach (rst_t[i]) rd(rst_t[i][15:8], rst_t[i][7:0]);
    host.wr(8'h03, 8'hFE);
    rd(8'h03, 8'h0E);
    dis = rng[7:0] | 8'hC0;
    host.wr(8'h04, dis);
    rd(8'h04, dis & 8'h3F);
    host.wr(8'h07, 8'h07);
    host.wr(8'h05, 8'hFF);
    rd(8'h05, 8'h3F);
    host.wr(8'h05, 8'h12);
    repeat (4) @(posedge mclk_i);
    cmp8({2'h0, code}, 8'h12);
    host.wr(8'h07, 8'h00);
    host.wr(8'h06, 8'h0B);
    pin <= 1'b1;
    repeat (4) @(posedge mclk_i);
    rd(8'h04, 8'h80 | (dis & 8'h3F));
    repeat (80) @(posedge mclk_i);
    rd(8'h04, dis & 8'h3F);
    cmp8({2'h0, code}, 8'h0B);
    pin <= 1'b0;
    resetn_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
    resetn_i <= 1'b1;
    foreach (rst_t[i]) rd(rst_t[i][15:8], rst_t[i][7:0]);
    cmp8({2'h0, code}, 8'h10);
    finish_test();
  end
endmodule
`default_nettype wire
